// ==== common/ofirq_pkg.sv ====
// Package with register offsets, field positions, defaults and timing for the oscillator-fail and pin block.
package ofirq_pkg;
	// Register offsets.
	localparam logic [4:0] reg_calib   = 5'h08;
	localparam logic [4:0] reg_wdog    = 5'h09;
	localparam logic [4:0] reg_almcfg  = 5'h0a;
	localparam logic [4:0] reg_flags   = 5'h0f;
	localparam logic [4:0] reg_osc     = 5'h01;
	localparam logic [4:0] reg_ctrl    = 5'h10;
	localparam logic [4:0] reg_evstat  = 5'h11;
	localparam logic [4:0] reg_evmask  = 5'h12;
	// Field positions.
	localparam int bit_out          = 7;
	localparam int bit_freq_test    = 6;
	localparam int bit_halt         = 7;
	localparam int bit_alarm_pin    = 7;
	localparam int bit_square_wave  = 6;
	localparam int bit_backup_alarm = 5;
	localparam int bit_stop_irq_en  = 7;
	localparam int bit_stop_flag    = 2;
	localparam int bit_stamp        = 6;
	localparam int ev_stop_set      = 0;
	localparam int ev_osc_fail      = 1;
	// Control register bits.
	localparam int bit_init_pwr = 0;
	localparam int bit_bat_pwr  = 1;
	// Defaults.
	localparam logic [7:0] wdog_reset  = 8'h00;
	localparam logic [1:0] ev_reset    = 2'h0;
	localparam logic       one_bit     = 1'b1;
	localparam logic       zero_bit    = 1'b0;
	// Timing: oscillator must run this long before the flag may be cleared.
	localparam int osc_settle_s   = 4;
	localparam int clk_hz         = 100000000;
	localparam longint osc_settle_cycles = longint'(osc_settle_s) * longint'(clk_hz);
endpackage

// ==== common/ofirq_if.sv ====
// Interface carrying pin-drive decisions between the control core and the pin driver.
`timescale 1ns/1ps
interface ofirq_pin_if;
	logic       stop_irq;
	logic       out_level;
	logic       freq_test;
	logic       alarm_pin;
	logic       square_wave;
	logic [7:0] wdog;
	modport core (output stop_irq, output out_level, output freq_test,
		output alarm_pin, output square_wave, output wdog);
	modport pin  (input stop_irq, input out_level, input freq_test,
		input alarm_pin, input square_wave, input wdog);
endinterface

// ==== rtl/ofirq_pin.sv ====
// Pin driver deciding the open-drain level of the shared interrupt and output pin.
`timescale 1ns/1ps
module ofirq_pin (
	input  wire logic   mclk,
	input  wire logic   rst,
	ofirq_pin_if.pin    pif,
	output logic        pin_low
);
	wire plain_out;
	wire next_low;

	assign plain_out = !pif.freq_test && !pif.alarm_pin && !pif.square_wave
		&& (pif.wdog == ofirq_pkg::wdog_reset);
	assign next_low = pif.stop_irq || (plain_out && !pif.out_level);

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			pin_low <= ofirq_pkg::zero_bit;
		else
			pin_low <= next_low;
	end

	a_plain_low: assert property (@(posedge mclk) disable iff (rst)
		(plain_out && !pif.out_level) |=> pin_low) else $error("pin not low in plain mode");
	a_irq_low: assert property (@(posedge mclk) disable iff (rst)
		pif.stop_irq |=> pin_low) else $error("pin not low on interrupt");
	a_plain_high: assert property (@(posedge mclk) disable iff (rst)
		(plain_out && pif.out_level && !pif.stop_irq) |=> !pin_low) else $error("pin low with output bit set");
endmodule // ofirq_pin

// ==== rtl/ofirq_core.sv ====
// Oscillator-fail flag, its interrupt, pin driver control and power-up defaults of the clock chip.
// What this block does
// - Stop flag stays set until written zero.
// - Enable and flag together pull pin low.
// - Only writes release interrupt, not reads.
// - Plain mode: pin follows output bit.
// - In plain mode, output bit zero drives pin low.
// - Initial power clears watchdog and enables.
// - Initial power sets halt, out, flags.
// - Battery power-up: stamp set, test/watchdog cleared.
// - Other bits undefined at initial power.
// - Halt write or failure sets flag.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module ofirq_core (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [4:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	input  wire logic       osc_fail,
	output logic [7:0]      rdata,
	output logic            irq_pin_o,
	output logic            irq_pin_oe_n,
	output logic            evt_irq
);
	logic       osc_halt_bit;
	logic       out_level;
	logic       freq_test_enable;
	logic [7:0] watchdog;
	logic       alarm_pin_enable;
	logic       square_wave_enable;
	logic       backup_alarm_enable;
	logic       osc_stop_flag;
	logic       osc_stop_irq_enable;
	logic       power_down_stamp_flag;
	logic [1:0] ev_status;
	logic [1:0] ev_mask;
	logic       pin_low;
	logic       fail_q;

	ofirq_pin_if pif ();

	function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
		hit = (a == r);
	endfunction

	wire wr_calib  = wr && hit(addr, ofirq_pkg::reg_calib);
	wire wr_wdog   = wr && hit(addr, ofirq_pkg::reg_wdog);
	wire wr_almcfg = wr && hit(addr, ofirq_pkg::reg_almcfg);
	wire wr_flags  = wr && hit(addr, ofirq_pkg::reg_flags);
	wire wr_osc    = wr && hit(addr, ofirq_pkg::reg_osc);
	wire wr_ctrl   = wr && hit(addr, ofirq_pkg::reg_ctrl);
	wire wr_evstat = wr && hit(addr, ofirq_pkg::reg_evstat);
	wire wr_evmask = wr && hit(addr, ofirq_pkg::reg_evmask);
	// Power events arrive as writes to the control register, standing in for supply sensing.
	wire init_pwr  = wr_ctrl && wdata[ofirq_pkg::bit_init_pwr];
	wire bat_pwr   = wr_ctrl && wdata[ofirq_pkg::bit_bat_pwr] && !init_pwr;
	wire halt_set  = wr_osc && wdata[ofirq_pkg::bit_halt];
	wire fail_rise = osc_fail && !fail_q;
	wire stop_set  = halt_set || fail_rise || init_pwr;
	wire stop_clr  = wr_flags && !wdata[ofirq_pkg::bit_stop_flag];
	// A set in the same cycle as a clearing write wins, so a fresh failure is never lost.
	wire next_stop = stop_set ? ofirq_pkg::one_bit : (stop_clr ? ofirq_pkg::zero_bit : osc_stop_flag);
	wire [1:0] ev_in;
	wire [1:0] next_ev;

	assign ev_in[ofirq_pkg::ev_stop_set] = stop_set;
	assign ev_in[ofirq_pkg::ev_osc_fail] = fail_rise;

	// Each event bit is sticky and cleared by writing a one; a new event beats the clear.
	generate
		for (genvar gi = 0; gi < 2; gi++)
		begin : g_ev
			assign next_ev[gi] = ev_in[gi] || (ev_status[gi] && !(wr_evstat && wdata[gi]));
		end
	endgenerate

	wire [7:0] rd_mux =
		hit(addr, ofirq_pkg::reg_osc)    ? {osc_halt_bit, 7'h00} :
		hit(addr, ofirq_pkg::reg_calib)  ? {out_level, freq_test_enable, 6'h00} :
		hit(addr, ofirq_pkg::reg_wdog)   ? watchdog :
		hit(addr, ofirq_pkg::reg_almcfg) ? {alarm_pin_enable, square_wave_enable, backup_alarm_enable, 5'h00} :
		hit(addr, ofirq_pkg::reg_flags)  ? {1'b0, power_down_stamp_flag, 3'h0, osc_stop_flag, 2'h0} :
		hit(addr, ofirq_pkg::reg_evstat) ? {6'h00, ev_status} :
		hit(addr, ofirq_pkg::reg_evmask) ? {6'h00, ev_mask} : 8'h00;

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			watchdog            <= ofirq_pkg::wdog_reset;
			alarm_pin_enable    <= ofirq_pkg::zero_bit;
			backup_alarm_enable <= ofirq_pkg::zero_bit;
			square_wave_enable  <= ofirq_pkg::zero_bit;
			osc_stop_irq_enable <= ofirq_pkg::zero_bit;
			freq_test_enable    <= ofirq_pkg::zero_bit;
			osc_halt_bit          <= ofirq_pkg::one_bit;
			out_level             <= ofirq_pkg::one_bit;
			osc_stop_flag         <= ofirq_pkg::one_bit;
			power_down_stamp_flag <= ofirq_pkg::one_bit;
			ev_status <= ofirq_pkg::ev_reset;
			ev_mask   <= ofirq_pkg::ev_reset;
			fail_q    <= ofirq_pkg::zero_bit;
			rdata     <= 8'h00;
			evt_irq   <= ofirq_pkg::zero_bit;
		end
		else
		begin
			fail_q <= osc_fail;
			rdata <= rd ? rd_mux : 8'h00;
			osc_stop_flag <= next_stop;
			ev_status <= next_ev;
			evt_irq <= |(next_ev & ev_mask);
			if (wr_evmask)
				ev_mask <= wdata[1:0];
			if (init_pwr)
			begin
				watchdog            <= ofirq_pkg::wdog_reset;
				alarm_pin_enable    <= ofirq_pkg::zero_bit;
				backup_alarm_enable <= ofirq_pkg::zero_bit;
				square_wave_enable  <= ofirq_pkg::zero_bit;
				osc_stop_irq_enable <= ofirq_pkg::zero_bit;
				freq_test_enable    <= ofirq_pkg::zero_bit;
				osc_halt_bit          <= ofirq_pkg::one_bit;
				out_level             <= ofirq_pkg::one_bit;
				power_down_stamp_flag <= ofirq_pkg::one_bit;
			end
			else if (bat_pwr)
			begin
				power_down_stamp_flag <= ofirq_pkg::one_bit;
				freq_test_enable      <= ofirq_pkg::zero_bit;
				watchdog              <= ofirq_pkg::wdog_reset;
			end
			else
			begin
				if (wr_osc)
					osc_halt_bit <= wdata[ofirq_pkg::bit_halt];
				if (wr_calib)
				begin
					out_level        <= wdata[ofirq_pkg::bit_out];
					freq_test_enable <= wdata[ofirq_pkg::bit_freq_test];
				end
				if (wr_wdog)
					watchdog <= wdata;
				if (wr_almcfg)
				begin
					alarm_pin_enable    <= wdata[ofirq_pkg::bit_alarm_pin];
					square_wave_enable  <= wdata[ofirq_pkg::bit_square_wave];
					backup_alarm_enable <= wdata[ofirq_pkg::bit_backup_alarm];
					osc_stop_irq_enable <= wdata[ofirq_pkg::bit_stop_irq_en];
				end
				if (wr_flags)
					power_down_stamp_flag <= wdata[ofirq_pkg::bit_stamp];
			end
		end
	end

	assign pif.stop_irq    = osc_stop_flag && osc_stop_irq_enable;
	assign pif.out_level   = out_level;
	assign pif.freq_test   = freq_test_enable;
	assign pif.alarm_pin   = alarm_pin_enable;
	assign pif.square_wave = square_wave_enable;
	assign pif.wdog        = watchdog;

	ofirq_pin u_pin (
		.mclk    (mclk),
		.rst     (rst),
		.pif     (pif),
		.pin_low (pin_low)
	);

	// Open drain: the level is always low and the active-low enable decides whether it is driven.
	// The extra stage keeps both pin outputs straight from flip-flops, at the cost of one cycle of latency.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			irq_pin_o    <= ofirq_pkg::zero_bit;
			irq_pin_oe_n <= ofirq_pkg::one_bit;
		end
		else
		begin
			irq_pin_o    <= ofirq_pkg::zero_bit;
			irq_pin_oe_n <= !pin_low;
		end
	end

	// The stop flag only falls on an explicit zero write that no set event overrides.
	a_stop_sticky: assert property (@(posedge mclk) disable iff (rst)
		(osc_stop_flag && !stop_clr) |=> osc_stop_flag)
		else $error("stop flag dropped without clear");
	a_stop_clear: assert property (@(posedge mclk) disable iff (rst)
		(stop_clr && !stop_set) |=> !osc_stop_flag)
		else $error("stop flag not cleared by zero write");
	a_flags_read: assert property (@(posedge mclk) disable iff (rst)
		(rd && hit(addr, ofirq_pkg::reg_flags)) |=> (rdata[ofirq_pkg::bit_stop_flag] == $past(osc_stop_flag)))
		else $error("flags read does not show stop flag");

	// Reads never disturb the flag or release the interrupt.
	a_read_keeps: assert property (@(posedge mclk) disable iff (rst)
		(rd && osc_stop_flag && !wr) |=> osc_stop_flag)
		else $error("read changed stop flag");
	a_irq_release: assert property (@(posedge mclk) disable iff (rst)
		(pif.stop_irq && !wr) |=> pif.stop_irq)
		else $error("interrupt released without write");
	a_enable_release: assert property (@(posedge mclk) disable iff (rst)
		(wr_almcfg && !wdata[ofirq_pkg::bit_stop_irq_en]) |=> !pif.stop_irq)
		else $error("interrupt kept after enable cleared");

	// Every cause of an oscillator stop leaves the flag set.
	a_halt_sets: assert property (@(posedge mclk) disable iff (rst)
		halt_set |=> osc_stop_flag)
		else $error("halt write did not set flag");
	a_fail_sets: assert property (@(posedge mclk) disable iff (rst)
		fail_rise |=> osc_stop_flag && ev_status[ofirq_pkg::ev_osc_fail])
		else $error("oscillator failure did not set flag");
	a_event_sticky: assert property (@(posedge mclk) disable iff (rst)
		(ev_status[ofirq_pkg::ev_osc_fail] && !(wr_evstat && wdata[ofirq_pkg::ev_osc_fail]))
		|=> ev_status[ofirq_pkg::ev_osc_fail])
		else $error("failure event dropped without clear");

	// Power-up defaults.
	a_init_zeros: assert property (@(posedge mclk) disable iff (rst)
		init_pwr |=> (watchdog == ofirq_pkg::wdog_reset) && !alarm_pin_enable && !backup_alarm_enable
		&& !square_wave_enable && !osc_stop_irq_enable && !freq_test_enable)
		else $error("initial cleared bits wrong");
	a_init_ones: assert property (@(posedge mclk) disable iff (rst)
		init_pwr |=> osc_halt_bit && out_level && osc_stop_flag && power_down_stamp_flag)
		else $error("initial set bits wrong");
	a_bat_power: assert property (@(posedge mclk) disable iff (rst)
		bat_pwr |=> power_down_stamp_flag && !freq_test_enable && (watchdog == ofirq_pkg::wdog_reset))
		else $error("battery power-up wrong");
	a_bat_keeps: assert property (@(posedge mclk) disable iff (rst)
		(bat_pwr && !fail_rise) |=> (osc_halt_bit == $past(osc_halt_bit)) && (out_level == $past(out_level))
		&& (alarm_pin_enable == $past(alarm_pin_enable)) && (square_wave_enable == $past(square_wave_enable))
		&& (backup_alarm_enable == $past(backup_alarm_enable))
		&& (osc_stop_irq_enable == $past(osc_stop_irq_enable)) && (osc_stop_flag == $past(osc_stop_flag)))
		else $error("battery power-up changed kept bits");

	// The pin enable follows its cause two edges later: one in the driver, one in the output stage.
	a_irq_pin: assert property (@(posedge mclk) disable iff (rst)
		pif.stop_irq |-> ##2 !irq_pin_oe_n)
		else $error("pin not pulled on interrupt");
	a_plain_pin: assert property (@(posedge mclk) disable iff (rst)
		(!freq_test_enable && !alarm_pin_enable && !square_wave_enable
		&& (watchdog == ofirq_pkg::wdog_reset) && !out_level) |-> ##2 !irq_pin_oe_n)
		else $error("pin not pulled with output bit low");
	a_pin_release: assert property (@(posedge mclk) disable iff (rst)
		(!pif.stop_irq && (out_level || freq_test_enable || alarm_pin_enable || square_wave_enable
		|| (watchdog != ofirq_pkg::wdog_reset))) |-> ##2 irq_pin_oe_n)
		else $error("pin pulled without a cause");
endmodule // ofirq_core

// ==== tb/ofirq_host.sv ====
// Host model that drives the register port of the clock block.
`timescale 1ns/1ps
module ofirq_host #(
	parameter int settle_cycles = 16
) (
	input  wire logic       mclk,
	input  wire logic [7:0] rdata,
	output logic [4:0]      addr,
	output logic [7:0]      wdata,
	output logic            wr,
	output logic            rd
);
	initial
	begin
		addr  = 5'h00;
		wdata = 8'h00;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr    <= 1'b0;
	endtask

	// Read data are valid only in the cycle after the strobe.
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask

	// settle before clearing
	// The real wait is four seconds; a short count keeps the run brief.
	task automatic clear_flags();
		repeat (settle_cycles) @(posedge mclk);
		wr_reg(ofirq_pkg::reg_flags, 8'h00);
	endtask
endmodule // ofirq_host

// ==== tb/testbench.sv ====
// Self-checking bench for the stop flag, its interrupt, the output pin and the power-up defaults.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
	logic       mclk;
	logic       rst;
	logic [4:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic       osc_fail;
	logic [7:0] rdata;
	logic       irq_pin_o;
	logic       irq_pin_oe_n;
	logic       evt_irq;
	logic       pin;
	logic [7:0] v;
	int         failures;
	int         total_checks;

	// The pin is open drain with a pull-up, so a released pin reads high.
	assign pin = irq_pin_oe_n ? 1'b1 : irq_pin_o;

	ofirq_core dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .osc_fail(osc_fail),
		.rdata(rdata), .irq_pin_o(irq_pin_o), .irq_pin_oe_n(irq_pin_oe_n), .evt_irq(evt_irq));
	ofirq_host h (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	always #5 mclk = ~mclk;

	task automatic stop_test();
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
		h.rd_reg(a, v);
		`CHK(v & m, e);
	endtask

	task automatic pin_chk(input logic e);
		repeat (3) @(posedge mclk);
		#1;
		`CHK(pin, e);
	endtask

	task automatic t_defaults();
		rd_chk(ofirq_pkg::reg_osc, 8'h80, 8'h80);
		rd_chk(ofirq_pkg::reg_calib, 8'hc0, 8'h80);
		rd_chk(ofirq_pkg::reg_wdog, 8'hff, 8'h00);
		rd_chk(ofirq_pkg::reg_almcfg, 8'he0, 8'h00);
		rd_chk(ofirq_pkg::reg_flags, 8'h44, 8'h44);
		rd_chk(5'h1f, 8'hff, 8'h00);
		pin_chk(1'b1);
	endtask

	task automatic t_out_pin();
		h.wr_reg(ofirq_pkg::reg_calib, 8'h00);
		pin_chk(1'b0);
		h.wr_reg(ofirq_pkg::reg_calib, 8'h80);
		pin_chk(1'b1);
	endtask

	task automatic t_irq();
		h.wr_reg(ofirq_pkg::reg_almcfg, 8'h80);
		pin_chk(1'b0);
		h.rd_reg(ofirq_pkg::reg_flags, v);
		pin_chk(1'b0);
		h.clear_flags();
		pin_chk(1'b1);
		h.wr_reg(ofirq_pkg::reg_flags, 8'h04);
		rd_chk(ofirq_pkg::reg_flags, 8'h04, 8'h00);
		h.wr_reg(ofirq_pkg::reg_osc, 8'h80);
		h.wr_reg(ofirq_pkg::reg_osc, 8'h00);
		rd_chk(ofirq_pkg::reg_flags, 8'h04, 8'h04);
		rd_chk(ofirq_pkg::reg_flags, 8'h04, 8'h04);
		pin_chk(1'b0);
		h.wr_reg(ofirq_pkg::reg_almcfg, 8'h00);
		pin_chk(1'b1);
	endtask

	task automatic t_fail_evt();
		h.clear_flags();
		h.wr_reg(ofirq_pkg::reg_evstat, 8'h03);
		h.wr_reg(ofirq_pkg::reg_evmask, 8'h00);
		@(posedge mclk) osc_fail <= 1'b1;
		rd_chk(ofirq_pkg::reg_evstat, 8'h02, 8'h02);
		`CHK(evt_irq, 1'b0);
		h.wr_reg(ofirq_pkg::reg_evmask, 8'h02);
		pin_chk(1'b1);
		`CHK(evt_irq, 1'b1);
		@(posedge mclk) osc_fail <= 1'b0;
		rd_chk(ofirq_pkg::reg_flags, 8'h04, 8'h04);
		h.wr_reg(ofirq_pkg::reg_evstat, 8'h03);
		repeat (2) @(posedge mclk);
		#1;
		`CHK(evt_irq, 1'b0);
	endtask

	task automatic t_power();
		h.wr_reg(ofirq_pkg::reg_almcfg, 8'h20);
		h.wr_reg(ofirq_pkg::reg_calib, 8'h40);
		pin_chk(1'b1);
		h.wr_reg(ofirq_pkg::reg_wdog, 8'h0e);
		h.clear_flags();
		h.wr_reg(ofirq_pkg::reg_ctrl, 8'h02);
		pin_chk(1'b0);
		rd_chk(ofirq_pkg::reg_flags, 8'h44, 8'h40);
		rd_chk(ofirq_pkg::reg_calib, 8'hc0, 8'h00);
		rd_chk(ofirq_pkg::reg_wdog, 8'hff, 8'h00);
		rd_chk(ofirq_pkg::reg_almcfg, 8'he0, 8'h20);
		rd_chk(ofirq_pkg::reg_osc, 8'h80, 8'h00);
		h.wr_reg(ofirq_pkg::reg_wdog, 8'h0e);
		h.wr_reg(ofirq_pkg::reg_ctrl, 8'h01);
		rd_chk(ofirq_pkg::reg_almcfg, 8'he0, 8'h00);
		rd_chk(ofirq_pkg::reg_wdog, 8'hff, 8'h00);
		rd_chk(ofirq_pkg::reg_calib, 8'hc0, 8'h80);
		rd_chk(ofirq_pkg::reg_flags, 8'h44, 8'h44);
		rd_chk(ofirq_pkg::reg_osc, 8'h80, 8'h80);
		pin_chk(1'b1);
	endtask

	initial
	begin
		#200000;
		failures++;
		stop_test();
	end

	initial
	begin
		mclk = 1'b0;
		rst = 1'b1;
		osc_fail = 1'b0;
		failures = 0;
		total_checks = 0;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		t_defaults();
		t_out_pin();
		t_irq();
		t_fail_evt();
		t_power();
		stop_test();
	end
endmodule // testbench
